// ===== xmk_pkg.sv
// Purpose: shared constants and types for the external memory high mask keeper
// Assumes: 16-bit data address space, 8-bit data, Avalon-MM register slave
// Notes: register word at byte address 0x6c; control bits of own choice at 0x70
package xmk_pkg;
    localparam logic [7:0] XMK_CTRL_B_ADDR = 8'h6c;
    localparam logic [7:0] XMK_CTRL_A_ADDR = 8'h70;
    localparam int XMK_BK_BIT = 7;
    localparam int XMK_EN_BIT = 0;
    localparam int XMK_COMPAT_BIT = 1;
    localparam logic [7:0] XMK_CTRL_B_RMASK = 8'h87;
    localparam logic [7:0] XMK_CTRL_A_RMASK = 8'h03;
    localparam logic [7:0] XMK_RESET = 8'h00;
    localparam logic [15:0] XMK_INT_LIMIT = 16'h1100;
    localparam logic [15:0] XMK_INT_LIMIT_COMPAT = 16'h1000;
    localparam int XMK_CYCLE_LEN = 3;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } xmk_avl_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } xmk_avl_rsp_type;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } xmk_cpu_req_type;

    typedef enum logic [1:0] {XMK_IDLE, XMK_ADDR, XMK_STROBE, XMK_DONE} xmk_state_type;
endpackage

// ===== xmk_hi_pin.sv
// Purpose: one high-address pin mux between address bit and port register
// Assumes: mask count is the number of released pins from the top, all eight at seven
// Notes: combinational; registered at top level
`timescale 1ns/1ps
module xmk_hi_pin #(
    parameter int INDEX = 0
) (
    // select
    input wire logic mem_en,
    input wire logic [2:0] mask,
    // data
    input wire logic addr_bit,
    input wire logic port_bit,
    input wire logic port_dir,
    output logic pin_out,
    output logic pin_oe
);
    logic [3:0] driven_bits;
    logic released;
    always_comb begin
        // value 7 releases all pins, others drive 8 minus value
        driven_bits = (mask == 3'h7) ? 4'h0 : 4'(4'h8 - {1'b0, mask});
        released = (4'(INDEX) >= driven_bits);
        if (mem_en && !released) begin
            pin_out = addr_bit;
            pin_oe = 1'b1;
        end else begin
            pin_out = port_bit;
            pin_oe = port_dir;
        end
    end
endmodule // xmk_hi_pin

// ===== xmk_keeper.sv
// Overview of operation
// RL1: keeper on holds last driven low address/data level while lines float.
// RL2: keeper works whether or not the external memory interface is enabled.
// RL3: control bits six to three read zero; software writes zeros there.
// RL4: enabled with mask zero drives all eight high pins with address.
// RL5: mask value sets driven high bits: 8,7..2, none at seven.
// RL6: released high pins output port data register value instead.
// RL7: addresses below 4,352 are internal and start no external cycle.
// RL8: full address goes unchanged onto the external address lines.
// RL9: software with 32 KB memory avoids addresses above 0x90FF.
// RL10: compatibility mode makes internal space 4,096 bytes, external from 0x1000.
// RL11: enable switches memory pins to memory functions, clear restores ports.
// RL12: new mask value applies from the next external cycle.
//
// Purpose: external memory control register B, high mask and keeper
// Assumes: single clock, CPU request held until done pulse
// Notes: mask is latched at cycle start so a write cannot disturb a cycle
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module xmk_keeper
    import xmk_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // register bus
    input wire xmk_pkg::xmk_avl_req_type AVL_REQ,
    output xmk_pkg::xmk_avl_rsp_type AVL_RSP,
    // cpu data access
    input wire xmk_pkg::xmk_cpu_req_type CPU_REQ,
    output logic CPU_EXT_SEL,
    output logic CPU_DONE,
    output logic [7:0] CPU_RDATA,
    // port registers
    input wire logic [7:0] PORTA_DATA,
    input wire logic [7:0] PORTA_DIR,
    input wire logic [7:0] PORTC_DATA,
    input wire logic [7:0] PORTC_DIR,
    input wire logic [2:0] PORTG_DATA,
    input wire logic [2:0] PORTG_DIR,
    // low address/data pins
    input wire logic [7:0] AD_IN,
    output logic [7:0] AD_OUT,
    output logic [7:0] AD_OE,
    output logic [7:0] AD_KEEP,
    // high address pins
    output logic [7:0] HI_OUT,
    output logic [7:0] HI_OE,
    // strobes: bit 0 write, 1 read, 2 latch
    output logic [2:0] STB_OUT,
    output logic [2:0] STB_OE
);
    import xmk_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic bk_en;
        logic [2:0] mask;
        logic mem_en;
        logic compat;
        logic [2:0] cyc_mask;
        xmk_state_type st;
        logic [15:0] addr;
        logic wr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
        logic [7:0] ad_last;
        logic [31:0] avl_rdata;
        logic avl_ack;
        logic [7:0] hi_out;
        logic [7:0] hi_oe;
    } xmk_state_all_type;

    xmk_state_all_type s_reg, s_next;
    logic [7:0] hi_pin_out, hi_pin_oe;
    logic [15:0] limit;
    logic ext_hit;
    logic avl_req;
    logic [7:0] ad_drive, ad_oe_c;
    logic [2:0] stb_c;

    // ****************************************
    // high address pin muxes
    // ****************************************
    for (genvar i = 0; i < 8; i++) begin : g_hi
        xmk_hi_pin #(.INDEX(i)) u_pin (
            .mem_en(s_reg.mem_en), // RL4
            .mask(s_reg.st == XMK_IDLE ? s_reg.mask : s_reg.cyc_mask), // RL5 RL12
            .addr_bit(s_reg.addr[8 + i]), // RL8
            .port_bit(PORTC_DATA[i]), // RL6
            .port_dir(PORTC_DIR[i]),
            .pin_out(hi_pin_out[i]),
            .pin_oe(hi_pin_oe[i])
        );
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.avl_ack = 1'b0;
        limit = s_reg.compat ? XMK_INT_LIMIT_COMPAT : XMK_INT_LIMIT; // RL10
        ext_hit = s_reg.mem_en && (CPU_REQ.addr >= limit); // RL7
        avl_req = (AVL_REQ.read || AVL_REQ.write) && !s_reg.avl_ack;

        // register slave: one wait cycle, then ack
        if (avl_req) begin
            s_next.avl_ack = 1'b1;
            if (AVL_REQ.write) begin
                if (AVL_REQ.address == XMK_CTRL_B_ADDR) begin
                    s_next.bk_en = AVL_REQ.writedata[XMK_BK_BIT]; // RL1
                    s_next.mask = AVL_REQ.writedata[2:0];
                end else if (AVL_REQ.address == XMK_CTRL_A_ADDR) begin
                    s_next.mem_en = AVL_REQ.writedata[XMK_EN_BIT]; // RL11
                    s_next.compat = AVL_REQ.writedata[XMK_COMPAT_BIT];
                end
            end else begin
                if (AVL_REQ.address == XMK_CTRL_B_ADDR) begin
                    // reserved bits forced to zero
                    s_next.avl_rdata = {24'h0, {s_reg.bk_en, 4'h0, s_reg.mask}
                        & XMK_CTRL_B_RMASK}; // RL3
                end else if (AVL_REQ.address == XMK_CTRL_A_ADDR) begin
                    s_next.avl_rdata = {24'h0, {6'h0, s_reg.compat, s_reg.mem_en}
                        & XMK_CTRL_A_RMASK};
                end else begin
                    s_next.avl_rdata = 32'h0;
                end
            end
        end

        // external cycle
        case (s_reg.st)
            XMK_IDLE: begin
                if ((CPU_REQ.rd || CPU_REQ.wr) && ext_hit && !s_reg.done) begin
                    s_next.addr = CPU_REQ.addr; // RL8
                    s_next.wr = CPU_REQ.wr;
                    s_next.wdata = CPU_REQ.wdata;
                    s_next.cyc_mask = s_reg.mask; // RL12
                    s_next.st = XMK_ADDR;
                end
            end
            XMK_ADDR: s_next.st = XMK_STROBE;
            XMK_STROBE: begin
                if (!s_reg.wr) begin
                    s_next.rdata = AD_IN;
                end
                s_next.st = XMK_DONE;
            end
            XMK_DONE: begin
                s_next.done = 1'b1;
                s_next.st = XMK_IDLE;
            end
            default: s_next.st = XMK_IDLE;
        endcase

        // hold last driven level for the keeper
        if (ad_oe_c != 8'h00) begin
            s_next.ad_last = ad_drive; // RL1
        end
        s_next.hi_out = hi_pin_out;
        s_next.hi_oe = hi_pin_oe;

        if (SRST) begin
            s_next = '0;
            s_next.st = XMK_IDLE;
        end
    end

    always_ff @(posedge CLOCK) begin
        s_reg <= s_next;
    end

    // ****************************************
    // pin drive
    // ****************************************
    always_comb begin
        if (s_reg.mem_en) begin // RL11
            ad_oe_c = (s_reg.st == XMK_ADDR || (s_reg.st != XMK_IDLE && s_reg.wr))
                ? 8'hff : 8'h00;
            ad_drive = (s_reg.st == XMK_ADDR) ? s_reg.addr[7:0] : s_reg.wdata;
            stb_c[0] = !(s_reg.st == XMK_STROBE && s_reg.wr);
            stb_c[1] = !(s_reg.st == XMK_STROBE && !s_reg.wr);
            stb_c[2] = (s_reg.st == XMK_ADDR);
            STB_OE = 3'h7;
        end else begin
            ad_oe_c = PORTA_DIR;
            ad_drive = PORTA_DATA;
            stb_c = PORTG_DATA;
            STB_OE = PORTG_DIR;
        end
    end

    assign AD_OUT = (ad_oe_c != 8'h00) ? ad_drive : s_reg.ad_last;
    assign AD_OE = ad_oe_c;
    // keeper independent of enable
    assign AD_KEEP = s_reg.bk_en ? ~ad_oe_c : 8'h00; // RL1 RL2
    assign STB_OUT = stb_c;
    assign HI_OUT = s_reg.hi_out;
    assign HI_OE = s_reg.hi_oe;
    assign CPU_EXT_SEL = ext_hit;
    assign CPU_DONE = s_reg.done;
    assign CPU_RDATA = s_reg.rdata;
    assign AVL_RSP.readdata = s_reg.avl_rdata;
    assign AVL_RSP.waitrequest = (AVL_REQ.read || AVL_REQ.write) && !s_reg.avl_ack;
endmodule // xmk_keeper

// ===== xmk_keeper_monitor.sv
// Purpose: pin and bus checker for xmk_keeper
// Assumes: bound to xmk_keeper
// Notes: sees top ports only
`timescale 1ns/1ps
module xmk_keeper_monitor
    import xmk_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // bus and cpu
    input wire xmk_pkg::xmk_avl_req_type AVL_REQ,
    input wire xmk_pkg::xmk_avl_rsp_type AVL_RSP,
    input wire xmk_pkg::xmk_cpu_req_type CPU_REQ,
    input wire logic CPU_EXT_SEL,
    input wire logic CPU_DONE,
    // pins
    input wire logic [7:0] AD_OUT,
    input wire logic [7:0] AD_OE,
    input wire logic [2:0] STB_OUT,
    input wire logic [2:0] STB_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    sequence ale_s; $rose(STB_OUT[2]); endsequence
    sequence done_s; ##3 CPU_DONE; endsequence
    rsv_zero_a: assert property (AVL_REQ.read && !AVL_RSP.waitrequest
        |-> (AVL_RSP.readdata & 32'hffffff78) == 32'h0) else $error("reserved bits set");
    bus_wait_a: assert property ($rose(AVL_REQ.read || AVL_REQ.write)
        |-> AVL_RSP.waitrequest ##1 !AVL_RSP.waitrequest) else $error("bus answer late");
    ext_only_a: assert property (ale_s |-> $past(CPU_EXT_SEL)) else $error("internal cycle");
    ale_addr_a: assert property (ale_s |-> AD_OUT == CPU_REQ.addr[7:0] && AD_OE == 8'hff)
        else $error("low address wrong");
    cycle_len_a: assert property (ale_s |-> done_s) else $error("done late");
    low_int_a: assert property (CPU_REQ.addr < XMK_INT_LIMIT_COMPAT |-> !CPU_EXT_SEL)
        else $error("low address external");
    keep_hold_a: assert property (AD_OE == 8'h0 && $past(AD_OE) == 8'h0 |-> $stable(AD_OUT))
        else $error("floating level lost");
    strobe_excl_a: assert property (STB_OE[1] |-> STB_OUT[1:0] != 2'b00)
        else $error("both strobes");
endmodule // xmk_keeper_monitor

// ===== xmk_sram_model.sv
// Purpose: 32 KB memory with its top address line unconnected
// Assumes: latch strobe high, read and write strobes low
// Notes: lines neither driven nor kept toggle every cycle
`timescale 1ns/1ps
module xmk_sram_model (
    // pins
    input wire logic clk,
    input wire logic [7:0] ad_out,
    input wire logic [7:0] ad_oe,
    input wire logic [7:0] ad_keep,
    input wire logic [7:0] hi_out,
    input wire logic [2:0] stb_out,
    input wire logic [2:0] stb_oe,
    output logic [7:0] ad_in
);
    logic [7:0] mem_reg [0:32767];
    logic [7:0] lo_reg;
    logic [7:0] flt_reg = 8'h5a;
    logic [7:0] hold;
    assign hold = ad_oe | ad_keep;
    assign ad_in = (stb_oe[1] && !stb_out[1]) ? mem_reg[{hi_out[6:0], lo_reg}]
        : (ad_out & hold) | (flt_reg & ~hold);
    always @(posedge clk) begin
        flt_reg <= ~ad_in;
        if (stb_oe[2] && stb_out[2]) lo_reg <= ad_out;
        if (stb_oe[0] && !stb_out[0]) mem_reg[{hi_out[6:0], lo_reg}] <= ad_in;
    end
endmodule // xmk_sram_model

// ===== xmk_keeper_test.sv
// Purpose: self-checking bench for xmk_keeper
// Assumes: memory model on the pins
// Notes: reads queue their expected value for the watcher
`timescale 1ns/1ps
module xmk_keeper_test;
    import xmk_pkg::*;
    logic CLOCK = 1'b0;
    logic SRST = 1'b1;
    xmk_avl_req_type AVL_REQ = '0;
    xmk_avl_rsp_type AVL_RSP;
    xmk_cpu_req_type CPU_REQ = '0;
    logic CPU_EXT_SEL, CPU_DONE;
    logic [7:0] CPU_RDATA, AD_IN, AD_OUT, AD_OE, AD_KEEP, HI_OUT, HI_OE;
    logic [7:0] PORTC_DATA = 8'h00;
    logic [7:0] PORTC_DIR = 8'hff;
    logic [2:0] STB_OUT, STB_OE;
    logic [7:0] exp_q [$];
    logic [15:0] hs;
    int err_count = 0;
    int total_checks = 0;
    always #12.5 CLOCK = ~CLOCK;
    xmk_keeper dut (.CLOCK(CLOCK), .SRST(SRST), .AVL_REQ(AVL_REQ), .AVL_RSP(AVL_RSP),
        .CPU_REQ(CPU_REQ), .CPU_EXT_SEL(CPU_EXT_SEL), .CPU_DONE(CPU_DONE),
        .CPU_RDATA(CPU_RDATA), .PORTA_DATA(8'h00), .PORTA_DIR(8'h00), .PORTC_DATA(PORTC_DATA),
        .PORTC_DIR(PORTC_DIR), .PORTG_DATA(3'h0), .PORTG_DIR(3'h0), .AD_IN(AD_IN),
        .AD_OUT(AD_OUT), .AD_OE(AD_OE), .AD_KEEP(AD_KEEP), .HI_OUT(HI_OUT), .HI_OE(HI_OE),
        .STB_OUT(STB_OUT), .STB_OE(STB_OE));
    xmk_sram_model mem (.clk(CLOCK), .ad_out(AD_OUT), .ad_oe(AD_OE), .ad_keep(AD_KEEP),
        .hi_out(HI_OUT), .stb_out(STB_OUT), .stb_oe(STB_OE), .ad_in(AD_IN));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 40) begin
            err_count++;
            close_out;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, e);
        int n = 0;
        @(posedge CLOCK);
        if (!w) exp_q.push_back(e);
        AVL_REQ <= '{a, !w, w, {24'h0, d}};
        do @(posedge CLOCK); while (AVL_RSP.waitrequest && ++n < 40);
        tmo(n);
        AVL_REQ <= '0;
    endtask
    // k marks the high pins that still carry address
    task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d, e, k);
        int n = 0;
        @(posedge CLOCK);
        if (!w) exp_q.push_back(e);
        CPU_REQ <= '{a, !w, w, d};
        hs = 16'h0;
        do begin
            @(posedge CLOCK);
            if (STB_OE[1] && STB_OUT[1:0] != 2'b11) hs = {HI_OE, HI_OUT};
        end while (!CPU_DONE && ++n < 40);
        tmo(n);
        CPU_REQ <= '0;
        chk("high pins", {k | PORTC_DIR, (a[15:8] & k) | (PORTC_DATA & ~k)}, hs);
    endtask
    always @(posedge CLOCK) begin
        if ((AVL_REQ.read && !AVL_RSP.waitrequest) || (CPU_DONE && CPU_REQ.rd))
            chk("read data", {8'h00, exp_q.pop_front()},
                {8'h00, AVL_REQ.read ? AVL_RSP.readdata[7:0] : CPU_RDATA});
    end
    initial begin
        static logic [15:0] ta [4] = '{16'h0fff, 16'h1000, 16'h10ff, 16'h1100};
        logic [3:0] s;
        void'($urandom(84363));
        repeat (20) @(posedge CLOCK);
        SRST <= 1'b0;
        bus(0, XMK_CTRL_B_ADDR, 8'h00, 8'h00);
        bus(1, XMK_CTRL_B_ADDR, 8'hff, 8'h00);
        bus(0, XMK_CTRL_B_ADDR, 8'h00, 8'h87);
        bus(0, 8'h10, 8'h00, 8'h00);
        @(posedge CLOCK);
        chk("keeper on", 16'h00ff, {STB_OE, 5'h0, AD_KEEP});
        $display("registers and keeper done");
        for (int c = 0; c < 2; c++) begin
            bus(1, XMK_CTRL_A_ADDR, 8'h01 + 8'(2 * c), 8'h00);
            for (int i = 0; i < 4; i++) begin
                CPU_REQ.addr <= ta[i];
                @(posedge CLOCK);
                s[i] = CPU_EXT_SEL;
            end
            chk("ext select", {12'h0, 1'b1, c[0], c[0], 1'b0}, {12'h0, s});
        end
        bus(1, XMK_CTRL_A_ADDR, 8'h01, 8'h00);
        for (int i = 0; i < 8; i++) begin
            PORTC_DATA <= 8'($urandom);
            PORTC_DIR <= 8'($urandom);
            bus(1, XMK_CTRL_B_ADDR, 8'(i), 8'h00);
            // stay at or below 0x90ff so the 32 KB memory is not aliased twice
            cpu(1, 16'($urandom_range(16'h90ff, 16'h1100)), 8'($urandom), 8'h00,
                i == 7 ? 8'h00 : 8'hff >> i);
        end
        PORTC_DATA <= 8'h00;
        bus(1, XMK_CTRL_B_ADDR, 8'h03, 8'h00);
        cpu(1, 16'h2001, 8'haa, 8'h00, 8'h1f);
        bus(1, XMK_CTRL_B_ADDR, 8'h00, 8'h00);
        cpu(0, 16'h8001, 8'h00, 8'haa, 8'hff);
        cpu(1, 16'h9000, 8'h5c, 8'h00, 8'hff);
        bus(1, XMK_CTRL_B_ADDR, 8'h03, 8'h00);
        cpu(0, 16'h3000, 8'h00, 8'h5c, 8'h1f);
        bus(1, XMK_CTRL_A_ADDR, 8'h00, 8'h00);
        repeat (2) @(posedge CLOCK);
        chk("ports back", {PORTC_DIR, 8'h00}, {HI_OE, AD_KEEP | {5'h0, STB_OE}});
        $display("memory cycles done");
        close_out;
    end
endmodule // xmk_keeper_test
bind xmk_keeper xmk_keeper_monitor mon (.CLOCK(CLOCK), .SRST(SRST), .AVL_REQ(AVL_REQ),
    .AVL_RSP(AVL_RSP), .CPU_REQ(CPU_REQ), .CPU_EXT_SEL(CPU_EXT_SEL), .CPU_DONE(CPU_DONE),
    .AD_OUT(AD_OUT), .AD_OE(AD_OE), .STB_OUT(STB_OUT), .STB_OE(STB_OE));
